// *** ucs_pkg.sv ***
// constants and types shared by the serial control and status flag block
package ucs_pkg;
  // register port layout
  localparam int ADDR_W = 2;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_STATUS_ONE = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 2'h3;
  // control one fields
  localparam int C1_WAKE = 1;
  localparam int C1_MLONG = 0;
  // control two fields
  localparam int C2_TIE = 7;
  localparam int C2_TCIE = 6;
  localparam int C2_RIE = 5;
  localparam int C2_ILIE = 4;
  localparam int C2_TE = 3;
  localparam int C2_RE = 2;
  localparam int C2_RWU = 1;
  localparam int C2_SBK = 0;
  // status one fields
  localparam int S1_TX_BUFFER_EMPTY_FLAG = 7;
  localparam int S1_TC = 6;
  localparam int S1_RX_BUFFER_FULL_FLAG = 5;
  // character time in bit times
  localparam logic [3:0] CHAR_BITS_SHORT = 4'ha;
  localparam logic [3:0] CHAR_BITS_LONG = 4'hb;
  // bit-rate divider default, in clock cycles per bit
  localparam int BIT_DIV_DEFAULT = 16;
  // reset and shifter load values
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [10:0] SHIFT_IDLE = 11'h7ff;
  localparam logic [10:0] SHIFT_BREAK = 11'h000;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_DATA = 2'b01,
    TX_BREAK = 2'b10,
    TX_PREAMBLE = 2'b11
  } ucs_tx_kind_t;
endpackage

// *** ucs_bit_tick.sv ***
// bit-rate divider giving a one-cycle enable pulse per bit time
module ucs_bit_tick #(
  parameter int DIV = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  output logic o_tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } ucs_tick_state_t;

  ucs_tick_state_t s;
  ucs_tick_state_t next_s;

  // count down one bit time, pulse at wrap
  always_comb begin
    next_s = s;
    next_s.tick = (s.cnt == '0);
    next_s.cnt = (s.cnt == '0) ? LAST : s.cnt - 1'b1;
  end

  // state register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_tick = s.tick;
endmodule // ucs_bit_tick

// *** ucs_flags.sv ***
// serial control and status flags with small frame engines
//
// Chosen here: the address map and strobed register access.
module ucs_flags
  import ucs_pkg::*;
#(
  parameter int BIT_DIV = BIT_DIV_DEFAULT
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_rxd,
  output logic [7:0] o_rdata,
  output logic o_txd,
  output logic o_txd_oe,
  output logic o_rx_owned,
  output logic o_irq
);
  typedef struct packed {
    logic wake;
    logic mlong;
    logic tx_empty_irq_en;
    logic tcie;
    logic rx_full_irq_en;
    logic ilie;
    logic te;
    logic re;
    logic rx_standby_request;
    logic break_queue;
    logic tx_buffer_empty_flag;
    logic tc;
    logic rx_buffer_full_flag;
    logic arm_tx_buffer_empty_flag;
    logic arm_tc;
    logic arm_rx_buffer_full_flag;
    logic brk_pending;
    logic idle_pending;
    logic [7:0] tx_buf;
    logic [7:0] rx_buf;
    logic [7:0] rdata;
    ucs_tx_kind_t tx_kind;
    logic [10:0] tx_shift;
    logic [3:0] tx_cnt;
    logic txd;
    logic txd_oe;
    logic rx_busy;
    logic [9:0] rx_shift;
    logic [3:0] rx_cnt;
    logic [3:0] rx_idle;
    logic rx_owned;
    logic irq;
  } ucs_state_t;

  ucs_state_t s;
  ucs_state_t next_s;
  logic rst_meta;
  logic rst_n;
  logic tick;
  logic wr_c1, wr_c2, wr_stat, wr_data, rd_stat, rd_data;
  logic te_rise, sbk_write, tx_buffer_empty_flag_set, tx_buffer_empty_flag_clr, tc_clr, rx_buffer_full_flag_set, rx_buffer_full_flag_clr;
  logic [3:0] char_len;
  logic [9:0] rx_word;
  logic tc_set;

  // reset release through two flip-flops
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // one bit time enable shared by both engines
  ucs_bit_tick #(.DIV(BIT_DIV)) u_tick (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .o_tick(tick)
  );

  // access decode
  assign wr_c1 = i_wr && (i_addr == ADDR_CTRL_ONE);
  assign wr_c2 = i_wr && (i_addr == ADDR_CTRL_TWO);
  assign wr_stat = i_wr && (i_addr == ADDR_STATUS_ONE);
  assign wr_data = i_wr && (i_addr == ADDR_DATA);
  assign rd_stat = i_rd && (i_addr == ADDR_STATUS_ONE);
  assign rd_data = i_rd && (i_addr == ADDR_DATA);
  assign char_len = s.mlong ? CHAR_BITS_LONG : CHAR_BITS_SHORT;
  assign te_rise = wr_c2 && i_wdata[C2_TE] && !s.te;
  assign sbk_write = wr_c2 && i_wdata[C2_SBK];
  assign rx_word = {i_rxd, s.rx_shift[9:1]};

  // next-state logic
  always_comb begin
    next_s = s;
    tx_buffer_empty_flag_set = 1'b0;
    rx_buffer_full_flag_set = 1'b0;
    // only armed flags clear on the following access
    tx_buffer_empty_flag_clr = wr_data && s.arm_tx_buffer_empty_flag;
    tc_clr = s.arm_tc && (wr_data || te_rise || sbk_write);
    rx_buffer_full_flag_clr = rd_data && s.arm_rx_buffer_full_flag;
    // register writes; status one ignores writes
    if (wr_c1) begin
      next_s.wake = i_wdata[C1_WAKE];
      next_s.mlong = i_wdata[C1_MLONG];
    end
    if (wr_c2) begin
      next_s.tx_empty_irq_en = i_wdata[C2_TIE];
      next_s.tcie = i_wdata[C2_TCIE];
      next_s.rx_full_irq_en = i_wdata[C2_RIE];
      next_s.ilie = i_wdata[C2_ILIE];
      next_s.te = i_wdata[C2_TE];
      next_s.re = i_wdata[C2_RE];
      next_s.rx_standby_request = i_wdata[C2_RWU];
      next_s.break_queue = i_wdata[C2_SBK];
    end
    if (wr_data) begin
      next_s.tx_buf = i_wdata;
    end
    // arming on status read, disarming on use
    if (rd_stat) begin
      next_s.arm_tx_buffer_empty_flag = s.tx_buffer_empty_flag;
      next_s.arm_tc = s.tc;
      next_s.arm_rx_buffer_full_flag = s.rx_buffer_full_flag;
    end
    if (tx_buffer_empty_flag_clr) next_s.arm_tx_buffer_empty_flag = 1'b0;
    if (tc_clr) next_s.arm_tc = 1'b0;
    if (rx_buffer_full_flag_clr) next_s.arm_rx_buffer_full_flag = 1'b0;

    // transmitter: finish current frame, else pick next job
    if (tick) begin
      if ((s.tx_kind != TX_IDLE) && (s.tx_cnt != 4'h0)) begin
        next_s.txd = s.tx_shift[0];
        next_s.tx_shift = {1'b1, s.tx_shift[10:1]};
        next_s.tx_cnt = s.tx_cnt - 4'h1;
      end else begin
        next_s.tx_kind = TX_IDLE;
        next_s.txd = 1'b1;
        next_s.tx_cnt = char_len;
        if (s.te && s.idle_pending) begin
          next_s.tx_kind = TX_PREAMBLE;
          next_s.tx_shift = SHIFT_IDLE;
          next_s.idle_pending = 1'b0;
        end else if (s.te && (s.brk_pending || s.break_queue)) begin
          next_s.tx_kind = TX_BREAK;
          next_s.tx_shift = SHIFT_BREAK;
          next_s.brk_pending = 1'b0;
        end else if (s.te && !s.tx_buffer_empty_flag) begin
          next_s.tx_kind = TX_DATA;
          next_s.tx_shift = {2'b11, s.tx_buf, 1'b0};
          tx_buffer_empty_flag_set = 1'b1;
        end else begin
          next_s.tx_cnt = 4'h0;
        end
      end
    end
    // new requests after the engine so a same-cycle start never eats them
    if (te_rise) next_s.idle_pending = 1'b1;
    if (sbk_write && !s.break_queue) next_s.brk_pending = 1'b1;

    // receiver: runs only while it owns the pin
    if (!s.re) begin
      next_s.rx_busy = 1'b0;
      next_s.rx_idle = 4'h0;
    end else if (tick) begin
      if (!s.rx_busy) begin
        if (!i_rxd) begin
          next_s.rx_busy = 1'b1;
          next_s.rx_cnt = char_len - 4'h1;
          next_s.rx_idle = 4'h0;
        end else if (s.rx_idle != char_len) begin
          next_s.rx_idle = s.rx_idle + 4'h1;
          // idle-line wakeup after a full character of ones
          if ((s.rx_idle == char_len - 4'h1) && s.rx_standby_request && !s.wake) begin
            next_s.rx_standby_request = 1'b0;
          end
        end
      end else begin
        next_s.rx_shift = rx_word;
        next_s.rx_cnt = s.rx_cnt - 4'h1;
        if (s.rx_cnt == 4'h1) begin
          next_s.rx_busy = 1'b0;
          if (!s.rx_standby_request || (s.wake && rx_word[8])) begin
            next_s.rx_standby_request = 1'b0;
            next_s.rx_buf = s.mlong ? rx_word[7:0] : rx_word[8:1];
            rx_buffer_full_flag_set = 1'b1;
          end
        end
      end
    end

    // flags: a set in the clearing cycle wins
    next_s.tx_buffer_empty_flag = tx_buffer_empty_flag_set || (s.tx_buffer_empty_flag && !tx_buffer_empty_flag_clr);
    next_s.rx_buffer_full_flag = rx_buffer_full_flag_set || (s.rx_buffer_full_flag && !rx_buffer_full_flag_clr);
    tc_set = next_s.tx_buffer_empty_flag && (next_s.tx_kind == TX_IDLE) &&
             !next_s.brk_pending && !next_s.idle_pending && !next_s.break_queue;
    next_s.tc = tc_set || (s.tc && !tc_clr);

    // pin ownership and interrupt request
    next_s.txd_oe = next_s.te || (next_s.tx_kind != TX_IDLE);
    next_s.rx_owned = next_s.re;
    next_s.irq = (next_s.tx_empty_irq_en && next_s.tx_buffer_empty_flag) ||
                 (next_s.tcie && next_s.tc) ||
                 (next_s.rx_full_irq_en && next_s.rx_buffer_full_flag);

    // read data stands the cycle after the strobe
    next_s.rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        ADDR_CTRL_ONE: begin
          next_s.rdata[C1_WAKE] = s.wake;
          next_s.rdata[C1_MLONG] = s.mlong;
        end
        ADDR_CTRL_TWO: begin
          next_s.rdata = {s.tx_empty_irq_en, s.tcie, s.rx_full_irq_en, s.ilie,
                          s.te, s.re, s.rx_standby_request, s.break_queue};
        end
        ADDR_STATUS_ONE: begin
          next_s.rdata[S1_TX_BUFFER_EMPTY_FLAG] = s.tx_buffer_empty_flag;
          next_s.rdata[S1_TC] = s.tc;
          next_s.rdata[S1_RX_BUFFER_FULL_FLAG] = s.rx_buffer_full_flag;
        end
        ADDR_DATA: begin
          next_s.rdata = s.rx_buf;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.tx_buffer_empty_flag <= 1'b1;
      s.tc <= 1'b1;
      s.tx_buf <= DATA_RESET;
      s.tx_shift <= SHIFT_IDLE;
      s.tx_kind <= TX_IDLE;
      s.txd <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign o_rdata = s.rdata;
  assign o_txd = s.txd;
  assign o_txd_oe = s.txd_oe;
  assign o_rx_owned = s.rx_owned;
  assign o_irq = s.irq;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n);

  // checks
  tx_buffer_empty_flag_load_a: assert property (
    tick && s.te && !s.tx_buffer_empty_flag && !s.break_queue && !s.brk_pending &&
    !s.idle_pending && (s.tx_kind == TX_IDLE || s.tx_cnt == 4'h0)
    |=> s.tx_buffer_empty_flag && s.tx_kind == TX_DATA)
    else $error("transmit empty not set on shifter load");
  tx_buffer_empty_flag_clear_a: assert property (
    wr_data && s.arm_tx_buffer_empty_flag && !tx_buffer_empty_flag_set |=> !s.tx_buffer_empty_flag)
    else $error("transmit empty not cleared by armed write");
  tc_idle_a: assert property (
    $rose(s.tc) |-> s.tx_buffer_empty_flag && s.tx_kind == TX_IDLE)
    else $error("transmit complete set while busy");
  tc_clear_a: assert property (
    wr_data && s.arm_tc && s.arm_tx_buffer_empty_flag && !tx_buffer_empty_flag_set |=> !s.tc)
    else $error("transmit complete not cleared after write");
  rx_buffer_full_flag_clear_a: assert property (
    rd_data && s.arm_rx_buffer_full_flag && !rx_buffer_full_flag_set |=> !s.rx_buffer_full_flag)
    else $error("receive full not cleared by armed read");
  status_ro_a: assert property (
    wr_stat && !(tick && (s.te || s.re)) |=>
    $stable(s.tx_buffer_empty_flag) && $stable(s.tc) && $stable(s.rx_buffer_full_flag))
    else $error("status write changed a flag");
  irq_tx_a: assert property (s.tx_empty_irq_en && s.tx_buffer_empty_flag |-> o_irq)
    else $error("transmit empty interrupt missing");
  irq_rx_a: assert property (s.rx_full_irq_en && s.rx_buffer_full_flag |-> o_irq)
    else $error("receive full interrupt missing");
  break_low_a: assert property (
    tick && s.tx_kind == TX_BREAK && s.tx_cnt != 4'h0 |=> !o_txd)
    else $error("break bit not low");
  rx_release_a: assert property (
    !s.re |-> !o_rx_owned ##1 !s.rx_busy)
    else $error("receiver active with pin released");
  idle_queue_a: assert property (
    te_rise |=> s.idle_pending || s.tx_kind == TX_PREAMBLE)
    else $error("idle character not queued");

  break_sent_c: cover property (s.tx_kind == TX_BREAK ##1
    s.tx_kind == TX_IDLE);
  char_rx_c: cover property (rx_buffer_full_flag_set);
  wake_c: cover property ($fell(s.rx_standby_request) && !wr_c2);
  tc_rise_c: cover property ($rose(s.tc));
endmodule // ucs_flags

// *** ucs_remote.sv ***
// remote serial device model facing the flag block's serial pins
module ucs_remote #(
  parameter int DIV = 4
) (
  input wire logic i_mclk,
  input wire logic i_txd,
  input wire logic i_txd_oe,
  output logic o_rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] sh;
  logic [7:0] last;
  int brk_cnt;
  // line idles high between frames
  initial begin
    o_rxd = 1'b1;
    brk_cnt = 0;
    last = 8'h00;
  end
  // one frame: start, eight data bits lsb first, stop
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rxd <= f[i];
      repeat (DIV) @(posedge i_mclk);
    end
  endtask
  // sample each outgoing frame mid bit; all zeros is a break
  initial forever begin
    @(posedge i_mclk);
    if (i_txd_oe === 1'b1 && i_txd === 1'b0) begin
      repeat (DIV / 2) @(posedge i_mclk);
      for (int k = 0; k < 9; k++) begin
        repeat (DIV) @(posedge i_mclk);
        sh = {i_txd, sh[8:1]};
      end
      if (sh === 9'h000) brk_cnt++;
      else last = sh[7:0];
      while (i_txd !== 1'b1) @(posedge i_mclk);
    end
  end
endmodule // ucs_remote

// *** test_uart_control_status_flags.sv ***
// register level test of the serial control and status flags
module test_uart_control_status_flags;
  import ucs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 4;
  logic mclk, resetn, wr, rd, rxd, txd, txd_oe, rx_owned, irq;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata, v;
  int fail_count, comparisons, n;

  ucs_flags #(.BIT_DIV(DIV)) DUT (
    .i_mclk(mclk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .i_rxd(rxd), .o_rdata(rdata), .o_txd(txd),
    .o_txd_oe(txd_oe), .o_rx_owned(rx_owned), .o_irq(irq)
  );
  ucs_remote #(.DIV(DIV)) u_remote (
    .i_mclk(mclk), .i_txd(txd), .i_txd_oe(txd_oe), .o_rxd(rxd)
  );

  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // read status until the masked flags match, bounded
  task automatic poll(input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] s;
    for (int i = 0; i < 500; i++) begin
      rd_reg(ADDR_STATUS_ONE, s);
      if ((s & mask) === exp) break;
    end
    chk(s & mask, exp);
  endtask
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    end_sim();
  end

  // main sequence
  initial begin
    resetn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = 8'h00;
    fail_count = 0;
    comparisons = 0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    // data write without an armed read leaves the flags
    wr_reg(ADDR_DATA, 8'h3c);
    rd_reg(ADDR_STATUS_ONE, v);
    chk(v, 8'hc0);
    wr_reg(ADDR_STATUS_ONE, 8'h00);
    rd_reg(ADDR_STATUS_ONE, v);
    chk(v, 8'hc0);
    wr_reg(ADDR_DATA, 8'h3c);
    rd_reg(ADDR_STATUS_ONE, v);
    chk(v, 8'h00);
    // enable transmitter: preamble, then the byte
    wr_reg(ADDR_CTRL_TWO, 8'h08);
    poll(8'hff, 8'hc0);
    chk(u_remote.last, 8'h3c);
    // one break: armed complete flag clears on break queue write
    wr_reg(ADDR_CTRL_TWO, 8'h09);
    rd_reg(ADDR_STATUS_ONE, v);
    chk(v, 8'h80);
    wr_reg(ADDR_CTRL_TWO, 8'h08);
    poll(8'hff, 8'hc0);
    chk(8'(u_remote.brk_cnt == 1 || u_remote.brk_cnt == 2), 8'h01);
    // break queue held keeps sending breaks
    n = u_remote.brk_cnt;
    wr_reg(ADDR_CTRL_TWO, 8'h09);
    repeat (40 * DIV) @(posedge mclk);
    wr_reg(ADDR_CTRL_TWO, 8'h08);
    poll(8'hff, 8'hc0);
    chk(8'(u_remote.brk_cnt - n >= 3), 8'h01);
    // transmit empty interrupt follows its enable
    wr_reg(ADDR_CTRL_TWO, 8'h88);
    repeat (2) @(posedge mclk);
    chk({7'h00, irq}, 8'h01);
    wr_reg(ADDR_CTRL_TWO, 8'h08);
    repeat (2) @(posedge mclk);
    chk({7'h00, irq}, 8'h00);
    // receive one character with its interrupt enabled
    wr_reg(ADDR_CTRL_TWO, 8'h2c);
    repeat (2) @(posedge mclk);
    chk({7'h00, rx_owned}, 8'h01);
    u_remote.send(8'ha5);
    poll(8'h20, 8'h20);
    chk({7'h00, irq}, 8'h01);
    rd_reg(ADDR_DATA, v);
    chk(v, 8'ha5);
    rd_reg(ADDR_STATUS_ONE, v);
    chk(v, 8'hc0);
    // standby with msb wakeup: first char dropped, second wakes
    wr_reg(ADDR_CTRL_ONE, 8'h02);
    wr_reg(ADDR_CTRL_TWO, 8'h0e);
    u_remote.send(8'h12);
    repeat (4 * DIV) @(posedge mclk);
    rd_reg(ADDR_STATUS_ONE, v);
    chk(v, 8'hc0);
    rd_reg(ADDR_CTRL_TWO, v);
    chk(v, 8'h0e);
    u_remote.send(8'h92);
    poll(8'h20, 8'h20);
    rd_reg(ADDR_CTRL_TWO, v);
    chk(v, 8'h0c);
    rd_reg(ADDR_DATA, v);
    chk(v, 8'h92);
    // receiver off hands the pin back
    wr_reg(ADDR_CTRL_TWO, 8'h08);
    repeat (2) @(posedge mclk);
    chk({7'h00, rx_owned}, 8'h00);
    // idle line wakeup: a character time of ones ends standby
    wr_reg(ADDR_CTRL_ONE, 8'h00);
    wr_reg(ADDR_CTRL_TWO, 8'h0e);
    rd_reg(ADDR_CTRL_TWO, v);
    chk(v, 8'h0e);
    repeat (12 * DIV) @(posedge mclk);
    rd_reg(ADDR_CTRL_TWO, v);
    chk(v, 8'h0c);
    // long characters keep the low eight data bits
    wr_reg(ADDR_CTRL_ONE, 8'h01);
    u_remote.send(8'h5a);
    poll(8'h20, 8'h20);
    rd_reg(ADDR_DATA, v);
    chk(v, 8'h5a);
    // armed complete flag clears on a transmitter enable rise
    rd_reg(ADDR_STATUS_ONE, v);
    chk(v, 8'hc0);
    wr_reg(ADDR_CTRL_TWO, 8'h00);
    wr_reg(ADDR_CTRL_TWO, 8'h08);
    rd_reg(ADDR_STATUS_ONE, v);
    chk(v, 8'h80);
    poll(8'hff, 8'hc0);
    end_sim();
  end
endmodule // test_uart_control_status_flags
